// ### src/gsmc_menu_ctl.sv
// operator menu, span-clearing stage and calibration fault latches
// assumes switch pins are asynchronous; reading, range and events are on i_clk
`default_nettype none
module gsmc_menu_ctl #(
   parameter int SEC_CYC = gsmc_pkg::SEC_CYC,
   parameter int DEB_CYC = gsmc_pkg::DEB_CYC
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rstn,
   // magnet switch pins, active high
   input  wire logic              i_first_magnet_switch,
   input  wire logic              i_second_magnet_switch,
   // measurement side
   input  wire logic [6:0]        i_reading,
   input  wire logic              i_range50,
   input  wire logic              i_clear_start,
   input  wire logic              i_range_fault,
   input  wire logic              i_stab_fault,
   // display, loop and status
   output gsmc_pkg::gsmc_disp_type o_disp,
   output logic                   o_loop_zero,
   output logic [15:0]            o_status,
   output logic [6:0]             o_level
);
   import gsmc_pkg::*;

   typedef struct packed {
      logic [1:0]       s1;
      logic [1:0]       s2;
      logic [1:0]       sw;
      logic [1:0]       swp;
      logic [1:0][19:0] deb;
      logic [26:0]      tick_cnt;
      logic             tick;
      logic             blink;
      gsmc_state_type   st;
      gsmc_item_type    item;
      logic [3:0]       idx;
      logic [8:0]       sec;
      logic [2:0]       scr;
      logic [2:0]       hold;
      logic             wrel;
      logic             arrow;
      logic             dir;
      logic [6:0]       level;
      logic [6:0]       edit;
      logic             rng;
      logic             stb;
      logic             clr;
      gsmc_disp_type    disp;
      logic             loop0;
      logic [15:0]      stat;
   } gsmc_reg_type;

   gsmc_reg_type q;
   gsmc_reg_type n;
   logic         any_held;
   logic         released;
   logic         rd_below;
   logic         send;
   logic [6:0]   lvl_min;
   logic [6:0]   lvl_max;

   function automatic logic [6:0] clamp(input logic [6:0] v,
                                        input logic [6:0] lo,
                                        input logic [6:0] hi);
      if (v < lo) begin
         return lo;
      end
      if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   function automatic logic scroll_end(input logic tick, input logic [8:0] sec);
      return tick && (sec == SCROLL_S - 9'h001);
   endfunction

   assign any_held = |q.sw;
   assign released = (|q.swp) && !any_held;
   assign rd_below = i_reading < (i_range50 ? THR_HALF : THR_FULL);
   assign send     = scroll_end(q.tick, q.sec);
   assign lvl_min  = i_range50 ? LVL_MIN_HALF : LVL_MIN_FULL;
   assign lvl_max  = i_range50 ? LVL_MAX_HALF : LVL_MAX_FULL;

   always_comb begin
      n      = q;
      n.tick = 1'b0;
      // two-stage synchroniser and debounce per switch
      n.s1   = {i_second_magnet_switch, i_first_magnet_switch};
      n.s2   = q.s1;
      for (int k = 0; k < 2; k++) begin
         if (q.s2[k] == q.sw[k]) begin
            n.deb[k] = '0;
         end else if (q.deb[k] == 20'(DEB_CYC - 1)) begin
            n.deb[k] = '0;
            n.sw[k]  = q.s2[k];
         end else begin
            n.deb[k] = q.deb[k] + 20'h00001;
         end
      end
      n.swp = q.sw;
      // seconds timebase
      if (q.tick_cnt == 27'(SEC_CYC - 1)) begin
         n.tick_cnt = '0;
         n.tick     = 1'b1;
      end else begin
         n.tick_cnt = q.tick_cnt + 27'h0000001;
      end
      if (q.tick) begin
         n.blink = ~q.blink;
         n.sec   = q.sec + 9'h001;
      end
      // hold time of whichever switch is active
      if (!any_held) begin
         n.hold = '0;
         n.wrel = 1'b0;
      end else if (q.tick && q.hold != 3'h7) begin
         n.hold = q.hold + 3'h1;
      end

      case (q.st)
         ST_NORMAL: begin
            if (i_clear_start) begin
               n.st  = ST_CLEAR;
               n.sec = '0;
            end else if (q.sw == 2'b10 && q.hold == ENTER_S) begin
               n.st    = ST_MENU;
               n.item  = ITEM_STATUS;
               n.sec   = '0;
               n.scr   = '0;
               n.arrow = 1'b0;
               n.wrel  = 1'b1;
            end
         end
         ST_CLEAR: begin
            if (rd_below) begin
               n.st  = ST_SPAN_DONE;
               n.sec = '0;
               n.rng = 1'b0;
               n.stb = 1'b0;
               n.clr = 1'b0;
            end else if (q.sec == CLEAR_S) begin
               n.st  = ST_CLR_FLT;
               n.sec = '0;
               n.scr = '0;
               n.clr = 1'b1;
            end
         end
         ST_SPAN_DONE: begin
            if (send) begin
               n.st = ST_NORMAL;
            end
         end
         ST_CLR_FLT: begin
            if (send) begin
               n.sec = '0;
               n.scr = q.scr + 3'h1;
               if (q.scr == FAULT_SCROLLS - 3'h1) begin
                  n.st = ST_NORMAL;
               end
            end
         end
         ST_MENU: begin
            if (q.arrow) begin
               if (!any_held) begin
                  n.arrow = 1'b0;
                  n.sec   = '0;
                  n.scr   = '0;
                  n.item  = q.dir ? gsmc_item_type'(q.item + 3'h1)
                                  : gsmc_item_type'(q.item - 3'h1);
               end else if (q.hold == OPEN_S) begin
                  n.arrow = 1'b0;
                  n.wrel  = 1'b1;
                  n.sec   = '0;
                  n.scr   = '0;
                  if (q.item == ITEM_STATUS) begin
                     n.st  = ST_STATUS;
                     n.idx = '0;
                  end else if (q.item == ITEM_LEVEL) begin
                     n.st   = ST_EDIT;
                     n.edit = clamp(q.level, lvl_min, lvl_max);
                  end
               end
            end else if (send) begin
               n.sec = '0;
               if (any_held && !q.wrel) begin
                  n.arrow = 1'b1;
                  n.dir   = q.sw[1];
                  n.hold  = '0;
               end else if (q.scr == IDLE_SCROLLS - 3'h1) begin
                  n.st = ST_NORMAL;
               end else begin
                  n.scr = q.scr + 3'h1;
               end
            end
         end
         ST_STATUS: begin
            if (send) begin
               n.sec = '0;
               if (q.idx == N_STATUS - 4'h1) begin
                  n.st   = ST_MENU;
                  n.item = ITEM_STATUS;
                  n.scr  = '0;
               end else begin
                  n.idx = q.idx + 4'h1;
               end
            end
         end
         ST_EDIT: begin
            if (any_held && !q.wrel && q.hold == SAVE_S) begin
               n.level = q.edit;
               n.st    = ST_SAVED;
               n.sec   = '0;
               n.wrel  = 1'b1;
            end else if (released && !q.wrel) begin
               if (q.swp[1]) begin
                  n.edit = clamp(q.edit + 7'h01, lvl_min, lvl_max);
               end else begin
                  n.edit = clamp(q.edit - 7'h01, lvl_min, lvl_max);
               end
            end
         end
         ST_SAVED: begin
            if (send) begin
               n.st   = ST_MENU;
               n.item = ITEM_LEVEL;
               n.sec  = '0;
               n.scr  = '0;
            end
         end
         default: begin
            n.st = ST_NORMAL;
         end
      endcase

      // fault latches: an arriving event wins over a clear
      if (i_range_fault) begin
         n.rng = 1'b1;
      end
      if (i_stab_fault) begin
         n.stb = 1'b1;
      end

      // registered outputs follow the next state
      n.disp.item  = n.item;
      n.disp.idx   = n.idx;
      n.disp.level = n.edit;
      n.disp.arrow = ARW_NONE;
      if (n.st == ST_NORMAL && n.sw[1]) begin
         n.disp.arrow = ARW_RIGHT;
      end else if (n.st == ST_MENU && n.arrow) begin
         n.disp.arrow = n.dir ? ARW_RIGHT : ARW_LEFT;
      end
      n.loop0 = n.rng | n.stb | n.clr;
      case (n.st)
         ST_NORMAL:    n.disp.msg = (n.loop0 && n.blink) ? MSG_FAULT : MSG_READING;
         ST_SPAN_DONE: n.disp.msg = MSG_SPAN_DONE;
         ST_CLR_FLT:   n.disp.msg = MSG_CLR_FAULT;
         ST_MENU:      n.disp.msg = MSG_ITEM;
         ST_STATUS:    n.disp.msg = MSG_STATUS;
         ST_EDIT:      n.disp.msg = MSG_LEVEL;
         ST_SAVED:     n.disp.msg = MSG_SAVED;
         default:      n.disp.msg = MSG_READING;
      endcase
      n.stat               = '0;
      n.stat[ST_RANGE_BIT] = n.rng;
      n.stat[ST_STAB_BIT]  = n.stb;
      n.stat[ST_CLR_BIT]   = n.clr;
      n.stat[ST_CAL_BIT]   = n.st == ST_CLEAR || n.st == ST_SPAN_DONE
                             || n.st == ST_CLR_FLT;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q       <= '0;
         q.level <= LVL_RST;
      end else begin
         q <= n;
      end
   end

   assign o_disp      = q.disp;
   assign o_loop_zero = q.loop0;
   assign o_status    = q.stat;
   assign o_level     = q.level;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   clear_pass_a: assert property (
      (q.st == ST_CLEAR && rd_below) |=>
         (q.st == ST_SPAN_DONE && o_disp.msg == MSG_SPAN_DONE && !q.clr))
      else $error("clearing did not complete the span");

   clear_timeout_a: assert property (
      (q.st == ST_CLEAR && !rd_below && q.sec == CLEAR_S) |=>
         (q.st == ST_CLR_FLT && o_status[ST_CLR_BIT]))
      else $error("clearing timeout not flagged");

   clear_latch_a: assert property (
      (q.clr && q.st != ST_CLEAR) |=> q.clr)
      else $error("clearing fault dropped without a span");

   range_flag_a: assert property (
      i_range_fault |=> (o_status[ST_RANGE_BIT] && o_loop_zero))
      else $error("range fault not shown");

   stab_flag_a: assert property (
      i_stab_fault |=> (o_status[ST_STAB_BIT] && o_loop_zero))
      else $error("stability fault not shown");

   fault_alt_a: assert property (
      (q.st == ST_NORMAL && q.clr && q.blink) |-> o_disp.msg == MSG_FAULT)
      else $error("fault message not alternated");

   menu_enter_a: assert property (
      (q.st == ST_NORMAL && !i_clear_start && q.sw == 2'b10 && q.hold == ENTER_S)
         |=> (q.st == ST_MENU && q.item == ITEM_STATUS))
      else $error("menu not entered on long hold");

   menu_step_a: assert property (
      (q.st == ST_MENU && q.arrow && !any_held && q.dir) |=>
         (q.item == 3'($past(q.item) + 3'h1) && !q.arrow))
      else $error("right step went wrong");

   level_range_a: assert property (
      (q.st == ST_EDIT) |-> (q.edit >= lvl_min && q.edit <= lvl_max) [*2])
      else $error("span level outside limits");

   cal_bit_a: assert property (
      o_status[ST_CAL_BIT] == (q.st inside {ST_CLEAR, ST_SPAN_DONE, ST_CLR_FLT}))
      else $error("calibration bit wrong");

   clr_fault_c: cover property (q.st == ST_CLEAR ##1 q.st == ST_CLR_FLT);
   span_done_c: cover property (q.st == ST_CLEAR ##1 q.st == ST_SPAN_DONE);
   status_c:    cover property (q.st == ST_STATUS ##1 q.st == ST_MENU);
   saved_c:     cover property (q.st == ST_EDIT ##1 q.st == ST_SAVED);

endmodule // gsmc_menu_ctl
`default_nettype wire

// ### src/gsmc_pkg.sv
// constants and types for the gas sensor menu and span-clearing controller
// assumes a 100 MHz system clock and switch pins that are asynchronous to it
`default_nettype none
package gsmc_pkg;
   // clock and timebase
   localparam int CLK_HZ    = 100_000_000;
   localparam int TICK_S    = 1;
   localparam int SEC_CYC   = CLK_HZ * TICK_S;
   localparam int DEB_MS    = 10;
   localparam int DEB_CYC   = (CLK_HZ / 1000) * DEB_MS;
   // hold, scroll and clearing times in seconds (CLEAR_MIN in minutes), and scroll counts
   localparam logic [2:0] ENTER_S  = 3'h4;
   localparam logic [2:0] OPEN_S   = 3'h3;
   localparam logic [2:0] SAVE_S   = 3'h3;
   localparam logic [8:0] SCROLL_S = 9'h004;
   localparam int         CLEAR_MIN = 5;
   localparam logic [8:0] CLEAR_S  = 9'(CLEAR_MIN * 60);
   localparam logic [2:0] IDLE_SCROLLS  = 3'h4;
   localparam logic [2:0] FAULT_SCROLLS = 3'h2;
   // reading thresholds and span level limits, percent LEL
   localparam logic [6:0] THR_FULL     = 7'h05;
   localparam logic [6:0] THR_HALF     = 7'h02;
   localparam logic [6:0] LVL_MIN_FULL = 7'h05;
   localparam logic [6:0] LVL_MAX_FULL = 7'h5F;
   localparam logic [6:0] LVL_MIN_HALF = 7'h02;
   localparam logic [6:0] LVL_MAX_HALF = 7'h32;
   localparam logic [6:0] LVL_RST      = 7'h32;
   // status list length and status word bits
   localparam logic [3:0] N_STATUS     = 4'hE;
   localparam int         ST_RANGE_BIT = 0;
   localparam int         ST_STAB_BIT  = 1;
   localparam int         ST_CLR_BIT   = 2;
   localparam int         ST_CAL_BIT   = 14;

   typedef enum logic [3:0] {
      ST_NORMAL, ST_CLEAR, ST_SPAN_DONE, ST_CLR_FLT,
      ST_MENU, ST_STATUS, ST_EDIT, ST_SAVED
   } gsmc_state_type;

   typedef enum logic [2:0] {
      ITEM_STATUS, ITEM_LEVEL, ITEM_GAS_FACTOR, ITEM_CAL_FACTOR,
      ITEM_SERIAL, ITEM_BRIDGE, ITEM_OUT_CHECK, ITEM_DEFAULTS
   } gsmc_item_type;

   typedef enum logic [3:0] {
      MSG_READING, MSG_FAULT, MSG_SPAN_DONE, MSG_CLR_FAULT,
      MSG_ITEM, MSG_STATUS, MSG_LEVEL, MSG_SAVED
   } gsmc_msg_type;

   typedef enum logic [1:0] {ARW_NONE, ARW_LEFT, ARW_RIGHT} gsmc_arrow_type;

   typedef struct packed {
      gsmc_msg_type   msg;
      gsmc_arrow_type arrow;
      gsmc_item_type  item;
      logic [3:0]     idx;
      logic [6:0]     level;
   } gsmc_disp_type;
endpackage
`default_nettype wire

// ### verification/gsmc_operator.sv
// magnet operator model that drives both switch pins
// assumes the bench calls its tasks from a single process
`default_nettype none
module gsmc_operator (
   input  wire logic                   i_clk,
   input  wire gsmc_pkg::gsmc_disp_type i_disp,
   output var  logic                   o_first,
   output var  logic                   o_second
);
   timeunit 1ns;
   timeprecision 1ns;
   import gsmc_pkg::*;
   initial begin
      o_first  = 1'b0;
      o_second = 1'b0;
   end
   // hold one switch for n cycles, then leave both open long enough to be seen released
   task automatic hold(input logic sec, input int n);
      @(posedge i_clk);
      o_second <= sec;
      o_first  <= !sec;
      repeat (n) @(posedge i_clk);
      o_second <= 1'b0;
      o_first  <= 1'b0;
      repeat (12) @(posedge i_clk);
   endtask
   // hold through the scroll until the arrow shows, keep it extra cycles, then release
   task automatic arrow(input logic sec, input int extra);
      int k;
      @(posedge i_clk);
      o_second <= sec;
      o_first  <= !sec;
      for (k = 0; k < 400 && i_disp.arrow === ARW_NONE; k++) @(posedge i_clk);
      repeat (extra) @(posedge i_clk);
      o_second <= 1'b0;
      o_first  <= 1'b0;
      repeat (12) @(posedge i_clk);
   endtask
endmodule // gsmc_operator
`default_nettype wire

// ### verification/gsmc_menu_ctl_bench.sv
// self-checking bench for the menu and span-clearing controller
// assumes short timebase parameters: 20 cycles a second, 4 cycles debounce
`default_nettype none
module gsmc_menu_ctl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import gsmc_pkg::*;
   localparam int SEC = 20;
   logic          i_clk;
   logic          i_rstn;
   logic          sw1;
   logic          sw2;
   logic [6:0]    rd;
   logic          r50;
   logic          cs;
   logic          rf;
   logic          sf;
   gsmc_disp_type o_disp;
   logic          o_loop_zero;
   logic [15:0]   o_status;
   logic [6:0]    o_level;
   logic [17:0]   notes[$];
   int            n_mismatch = 0;
   int            n_checks = 0;
   logic [15:0]   st_p = 16'h0000;
   logic [6:0]    lv_p = LVL_RST;
   gsmc_disp_type d_p = '0;

   gsmc_menu_ctl #(.SEC_CYC(SEC), .DEB_CYC(4)) DUT (
      .i_clk(i_clk), .i_rstn(i_rstn),
      .i_first_magnet_switch(sw1), .i_second_magnet_switch(sw2),
      .i_reading(rd), .i_range50(r50), .i_clear_start(cs),
      .i_range_fault(rf), .i_stab_fault(sf),
      .o_disp(o_disp), .o_loop_zero(o_loop_zero), .o_status(o_status), .o_level(o_level));
   gsmc_operator op (.i_clk(i_clk), .i_disp(o_disp), .o_first(sw1), .o_second(sw2));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic note(input logic [1:0] kind, input logic [15:0] v);
      notes.push_back({kind, v});
   endtask
   task automatic take(input logic [17:0] got);
      if (notes.size() == 0)
         chk(got, 18'h3FFFF);
      else
         chk(got, notes.pop_front());
   endtask
   task automatic wait_msg(input gsmc_msg_type m, input int n);
      int k;
      @(negedge i_clk);
      for (k = 0; k < n && o_disp.msg !== m; k++) @(negedge i_clk);
      chk({14'h0000, o_disp.msg}, {14'h0000, m});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // result watcher: each change of status, stored level or shown item takes the oldest note
   always @(negedge i_clk) begin
      if (i_rstn) begin
         if (o_status !== st_p)
            take({2'h0, o_status});
         if (o_level !== lv_p)
            take({2'h1, 9'h000, o_level});
         if (o_disp.msg === MSG_ITEM && (d_p.msg !== MSG_ITEM || d_p.item !== o_disp.item))
            take({2'h2, 13'h0000, o_disp.item});
      end
      st_p = o_status;
      lv_p = o_level;
      d_p  = o_disp;
   end

   initial begin
      #400us;
      $display("wrong value at %0t: watchdog", $time);
      n_mismatch++;
      results();
   end

   initial begin
      int          k;
      int          j;
      logic        sec;
      logic [2:0]  it;
      logic [31:0] seed;
      i_rstn = 1'b0;
      rd = 7'h00;
      r50 = 1'b0;
      cs = 1'b0;
      rf = 1'b0;
      sf = 1'b0;
      seed = $urandom(32'h4E84);
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(negedge i_clk);
      chk({2'h0, o_status}, 18'h00000);
      chk({11'h000, o_level}, {11'h000, LVL_RST});
      chk({2'h0, o_disp[19:4]}, 18'h00000);
      chk({14'h0000, o_disp[3:0]}, 18'h00000);
      $display("test reset done");
      note(2'h0, 16'h0001);
      @(posedge i_clk) rf <= 1'b1;
      @(posedge i_clk) rf <= 1'b0;
      wait_msg(MSG_FAULT, 3 * SEC);
      wait_msg(MSG_READING, 3 * SEC);
      chk({17'h00000, o_loop_zero}, 18'h00001);
      note(2'h0, 16'h0003);
      @(posedge i_clk) sf <= 1'b1;
      @(posedge i_clk) sf <= 1'b0;
      wait_msg(MSG_FAULT, 3 * SEC);
      $display("test faults done");
      note(2'h0, 16'h4003);
      note(2'h0, 16'h4007);
      note(2'h0, 16'h0007);
      @(posedge i_clk) rd <= 7'(THR_FULL + $urandom % 90);
      cs <= 1'b1;
      @(posedge i_clk) cs <= 1'b0;
      repeat (290 * SEC) @(negedge i_clk);
      chk({2'h0, o_status}, 18'h04003);
      wait_msg(MSG_CLR_FAULT, 12 * SEC);
      repeat (11 * SEC) @(negedge i_clk);
      wait_msg(MSG_FAULT, 3 * SEC);
      $display("test clearing fault done");
      note(2'h0, 16'h4007);
      note(2'h0, 16'h4000);
      note(2'h0, 16'h0000);
      @(posedge i_clk) r50 <= 1'b1;
      rd <= THR_HALF;
      cs <= 1'b1;
      @(posedge i_clk) cs <= 1'b0;
      repeat (5 * SEC) @(negedge i_clk);
      @(posedge i_clk) rd <= THR_HALF - 7'h01;
      wait_msg(MSG_SPAN_DONE, 10);
      wait_msg(MSG_READING, 7 * SEC);
      chk({17'h00000, o_loop_zero}, 18'h00000);
      $display("test span clear done");
      note(2'h2, 16'h0000);
      fork
         op.hold(1'b1, 6 * SEC);
         begin
            repeat (40) @(negedge i_clk);
            chk({16'h0000, o_disp.arrow}, {16'h0000, ARW_RIGHT});
         end
      join
      it = 3'h0;
      for (k = 0; k < 6; k++) begin
         sec = (k == 0) ? 1'b0 : 1'($urandom % 2);
         it = sec ? it + 3'h1 : it - 3'h1;
         note(2'h2, {13'h0000, it});
         op.arrow(sec, 0);
      end
      while (it != 3'h0) begin
         it = it + 3'h1;
         note(2'h2, {13'h0000, it});
         op.arrow(1'b1, 0);
      end
      $display("test navigation done");
      op.arrow(1'b1, 5 * SEC);
      wait_msg(MSG_STATUS, 2 * SEC);
      note(2'h2, 16'h0000);
      for (k = 0; k < 14; k++) begin
         for (j = 0; j < 10 * SEC && o_disp.idx !== k[3:0]; j++) @(negedge i_clk);
         chk({14'h0000, o_disp.idx}, {14'h0000, k[3:0]});
      end
      wait_msg(MSG_ITEM, 10 * SEC);
      $display("test status list done");
      note(2'h2, 16'h0001);
      op.arrow(1'b1, 0);
      fork
         op.arrow(1'b0, 5 * SEC);
         begin
            for (j = 0; j < 400 && o_disp.arrow === ARW_NONE; j++) @(negedge i_clk);
            chk({16'h0000, o_disp.arrow}, {16'h0000, ARW_LEFT});
         end
      join
      wait_msg(MSG_LEVEL, 2 * SEC);
      chk({11'h000, o_disp.level}, 18'h00032);
      op.hold(1'b1, 30);
      @(negedge i_clk) chk({11'h000, o_disp.level}, {11'h000, LVL_MAX_HALF});
      op.hold(1'b0, 30);
      @(negedge i_clk) chk({11'h000, o_disp.level}, 18'h00031);
      note(2'h1, 16'h0031);
      note(2'h2, 16'h0001);
      op.hold(1'b0, 5 * SEC);
      wait_msg(MSG_SAVED, 2 * SEC);
      wait_msg(MSG_ITEM, 7 * SEC);
      $display("test level edit done");
      repeat (12 * SEC) @(negedge i_clk);
      chk({14'h0000, o_disp.msg}, {14'h0000, MSG_ITEM});
      wait_msg(MSG_READING, 10 * SEC);
      chk(18'(notes.size()), 18'h00000);
      $display("test idle exit done");
      results();
   end
endmodule // gsmc_menu_ctl_bench
`default_nettype wire
